/* File: src/hsp_map.svh */
`ifndef HSP_MAP_SVH
`define HSP_MAP_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define HSP_CLK_HZ        50000000
`define HSP_MS_PER_S      1000
`define HSP_BAUD_SLOW     19200
`define HSP_BAUD_FAST     115200
`define HSP_DIV_SLOW      (`HSP_CLK_HZ / `HSP_BAUD_SLOW)
`define HSP_DIV_FAST      (`HSP_CLK_HZ / `HSP_BAUD_FAST)
`define HSP_ACK_MS        250
`define HSP_FAN_MS        500
`define HSP_TEMP_MS       1000
`define HSP_TMR_W         26

// ****************************************************************
// serial frame
// ****************************************************************
`define HSP_BIT_START     4'h0
`define HSP_BIT_STOP      4'h9
`define HSP_BYTE_BITS     8

// ****************************************************************
// packet layout
// ****************************************************************
`define HSP_MAX_LEN       8'h12
`define HSP_BUF_DEPTH     18
`define HSP_CLS_CMD       2'h0
`define HSP_CLS_RSP       2'h1
`define HSP_CLS_RPT       2'h2
`define HSP_CLS_ERR       2'h3
`define HSP_CODE_PING     6'h00
`define HSP_CODE_BAUD     6'h21
`define HSP_PING_MAX      8'h10
`define HSP_BAUD_LEN      8'h01
`define HSP_BAUD_MAXSEL   8'h01
`define HSP_RPT_KEY       6'h00
`define HSP_RPT_FAN       6'h01
`define HSP_RPT_TEMP      6'h02
`define HSP_LEN_KEY       8'h01
`define HSP_LEN_FAN       8'h04
`define HSP_LEN_TEMP      8'h03
`define HSP_POS_LEN       5'h01
`define HSP_POS_DATA      5'h02
`define HSP_KEY_CODE_MAX  8'h0C
`define HSP_FAN_MAX_IDX   8'h03

// ****************************************************************
// checksum
// ****************************************************************
`define HSP_CRC_INIT      16'hFFFF
`define HSP_CRC_POLY      16'h8408
`define HSP_CRC_XOROUT    16'hFFFF

`endif

/* File: src/hsp_pkg.sv */
package hsp_pkg;
  typedef enum {RX_TYPE, RX_LEN, RX_DATA, RX_CRC_LO, RX_CRC_HI} hsp_rx_e;
  typedef enum {TX_IDLE, TX_SEND} hsp_tx_e;
  typedef logic [7:0] hsp_byte_t;
endpackage : hsp_pkg

/* File: src/hsp_crc16.sv */
`timescale 1ns/100ps
`include "hsp_map.svh"

module hsp_crc16 (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        clr,
  input  wire logic        upd,
  input  wire logic [7:0]  dat,
  output logic      [15:0] crc
);
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;
  logic [15:0] seed;

  // reflected crc, one byte per update
  always_comb begin
    seed    = clr ? `HSP_CRC_INIT : crc_ff;
    nxt_crc = seed;
    if (upd) begin
      nxt_crc = seed ^ {8'h00, dat};
      for (int i = 0; i < `HSP_BYTE_BITS; i++) begin
        nxt_crc = nxt_crc[0] ? ((nxt_crc >> 1) ^ `HSP_CRC_POLY) : (nxt_crc >> 1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) crc_ff <= `HSP_CRC_INIT;
    else if (clkEn) crc_ff <= nxt_crc;
  end

  assign crc = crc_ff;
endmodule : hsp_crc16

/* File: src/hsp_framer.sv */
`timescale 1ns/100ps
`include "hsp_map.svh"
// How it works
// R1: link starts at 19200 baud, 8N1
// R2: host command switches link to 115200 baud
// R3: packet is type, length, payload, checksum
// R4: type: two class bits, six code bits
// R5: class 00 cmd, 01 rsp, 10 rpt, 11 err
// R6: legal structure, illegal content gets error class
// R7: payload length 0 to 18 only
// R8: CRC16 over all bytes, low byte first
// R9: checksum right after last used payload byte
// R10: every command acknowledged within 250 ms
// R11: host waits for ack before next command
// R12: host retries after 250 ms, then flags fault
// R13: host buffers and drains packets fast enough
// R14: host sorts incoming packets by type byte
// R15: host resyncs on next valid packet
// R16: enabled key press/release sends 0x80 report
// R17: press codes 1-6, releases from 7
// R18: selected fans reported as 0x81 every 0.5s
// R19: fan payload: index, count, ticks high first
// R20: host decodes fan counts into speed
// R21: enabled temperature sensors reported every second
// R22: at most 32 sensor bus devices
// R23: ack code equals command code
// R24: temperatures reported as 0x82 per sensor
// R25: exit release is code 12
// R26: bad checksum packets dropped, no ack

module hsp_framer #(
  parameter int FAN_PERIOD_CYC  = `HSP_FAN_MS * (`HSP_CLK_HZ / `HSP_MS_PER_S),
  parameter int TEMP_PERIOD_CYC = `HSP_TEMP_MS * (`HSP_CLK_HZ / `HSP_MS_PER_S),
  parameter int ACK_CYC         = `HSP_ACK_MS * (`HSP_CLK_HZ / `HSP_MS_PER_S)
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        rxPin,
  output logic             txPin,
  input  wire logic [5:0]  keyLvl,
  input  wire logic [5:0]  keyPressEn,
  input  wire logic [5:0]  keyRelEn,
  input  wire logic [3:0]  fanRptEn,
  input  wire logic [31:0] fanTach,
  input  wire logic [63:0] fanTicks,
  input  wire logic [31:0] tempRptEn,
  input  wire logic [15:0] tempData,
  output logic      [4:0]  tempSel,
  output logic             baudFast,
  output logic             crcErr
);
  function automatic logic [4:0] lowIdx(input logic [31:0] v);
    lowIdx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) lowIdx = 5'(i);
    end
  endfunction : lowIdx

  // ****************************************************************
  // receive line and byte deserialiser
  // ****************************************************************
  logic [2:0]  syncRx_ff;
  logic        rxLvl_ff, nxt_rxLvl;
  logic        rxOn_ff, nxt_rxOn;
  logic [11:0] rxTmr_ff, nxt_rxTmr;
  logic [3:0]  rxBit_ff, nxt_rxBit;
  logic [7:0]  rxSh_ff, nxt_rxSh;
  logic        rxVld_ff, nxt_rxVld;
  logic        baudFast_ff, nxt_baudFast;
  logic [11:0] bitDiv;

  assign bitDiv = baudFast_ff ? 12'(`HSP_DIV_FAST) : 12'(`HSP_DIV_SLOW);  // see R1 see R2

  always_comb begin
    nxt_rxLvl = (syncRx_ff[1] == syncRx_ff[2]) ? syncRx_ff[2] : rxLvl_ff;
    nxt_rxOn  = rxOn_ff;
    nxt_rxTmr = rxTmr_ff;
    nxt_rxBit = rxBit_ff;
    nxt_rxSh  = rxSh_ff;
    nxt_rxVld = 1'b0;
    if (!rxOn_ff) begin
      if (!rxLvl_ff) begin
        nxt_rxOn  = 1'b1;
        nxt_rxTmr = bitDiv >> 1;
        nxt_rxBit = `HSP_BIT_START;
      end
    end else if (rxTmr_ff != 12'h000) begin
      nxt_rxTmr = rxTmr_ff - 12'h001;
    end else begin
      nxt_rxTmr = bitDiv - 12'h001;
      nxt_rxBit = rxBit_ff + 4'h1;
      if (rxBit_ff == `HSP_BIT_START) begin
        if (rxLvl_ff) nxt_rxOn = 1'b0;
      end else if (rxBit_ff == `HSP_BIT_STOP) begin  // see R1
        nxt_rxOn  = 1'b0;
        nxt_rxVld = rxLvl_ff;
      end else begin
        nxt_rxSh = {rxLvl_ff, rxSh_ff[7:1]};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      syncRx_ff <= 3'h7;
      rxLvl_ff  <= 1'b1;
      rxOn_ff   <= 1'b0;
      rxTmr_ff  <= 12'h000;
      rxBit_ff  <= 4'h0;
      rxSh_ff   <= 8'h00;
      rxVld_ff  <= 1'b0;
    end else if (clkEn) begin
      syncRx_ff <= {syncRx_ff[1:0], rxPin};
      rxLvl_ff  <= nxt_rxLvl;
      rxOn_ff   <= nxt_rxOn;
      rxTmr_ff  <= nxt_rxTmr;
      rxBit_ff  <= nxt_rxBit;
      rxSh_ff   <= nxt_rxSh;
      rxVld_ff  <= nxt_rxVld;
    end
  end

  // ****************************************************************
  // packet parser and command answer
  // ****************************************************************
  hsp_pkg::hsp_rx_e   rxSt_ff, nxt_rxSt;
  logic [4:0]         rxCnt_ff, nxt_rxCnt;
  hsp_pkg::hsp_byte_t rxType_ff, nxt_rxType, rxLen_ff, nxt_rxLen, rxCrcLo_ff, nxt_rxCrcLo;
  hsp_pkg::hsp_byte_t rxBuf_ff [`HSP_BUF_DEPTH];
  hsp_pkg::hsp_byte_t nxt_rxBuf [`HSP_BUF_DEPTH];
  logic [15:0]        rxCrc;
  logic               pktOk, crcBad, ldResp, baudGo;
  logic               respPend_ff, nxt_respPend, respOk_ff, nxt_respOk;
  logic [5:0]         respCode_ff, nxt_respCode;
  hsp_pkg::hsp_byte_t respLen_ff, nxt_respLen;
  logic               baudPend_ff, nxt_baudPend, baudVal_ff, nxt_baudVal;
  logic               crcErr_ff;

  hsp_crc16 uRxCrc (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .clr     (rxSt_ff == hsp_pkg::RX_TYPE),
    .upd     (rxVld_ff && (rxSt_ff inside {hsp_pkg::RX_TYPE, hsp_pkg::RX_LEN,
                                          hsp_pkg::RX_DATA})),  // see R8
    .dat     (rxSh_ff),
    .crc     (rxCrc)
  );

  // checksum arrives low byte first
  assign pktOk  = rxVld_ff && rxSt_ff == hsp_pkg::RX_CRC_HI &&
                  {rxSh_ff, rxCrcLo_ff} == (rxCrc ^ `HSP_CRC_XOROUT);  // see R8
  assign crcBad = rxVld_ff && rxSt_ff == hsp_pkg::RX_CRC_HI && !pktOk;  // see R26

  always_comb begin
    nxt_rxSt     = rxSt_ff;
    nxt_rxCnt    = rxCnt_ff;
    nxt_rxType   = rxType_ff;
    nxt_rxLen    = rxLen_ff;
    nxt_rxCrcLo  = rxCrcLo_ff;
    nxt_rxBuf    = rxBuf_ff;
    nxt_respPend = respPend_ff && !ldResp;
    nxt_respOk   = respOk_ff;
    nxt_respCode = respCode_ff;
    nxt_respLen  = respLen_ff;
    nxt_baudPend = baudPend_ff && !baudGo;
    nxt_baudVal  = baudVal_ff;
    nxt_baudFast = baudGo ? baudVal_ff : baudFast_ff;  // see R2
    if (rxVld_ff) begin
      unique case (rxSt_ff)  // see R3
        hsp_pkg::RX_TYPE: begin
          nxt_rxType = rxSh_ff;
          nxt_rxSt   = hsp_pkg::RX_LEN;
        end
        hsp_pkg::RX_LEN: begin
          nxt_rxLen = rxSh_ff;
          nxt_rxCnt = 5'h00;
          if (rxSh_ff > `HSP_MAX_LEN) nxt_rxSt = hsp_pkg::RX_TYPE;  // see R7
          else if (rxSh_ff == 8'h00) nxt_rxSt = hsp_pkg::RX_CRC_LO;  // see R9
          else nxt_rxSt = hsp_pkg::RX_DATA;
        end
        hsp_pkg::RX_DATA: begin
          nxt_rxBuf[rxCnt_ff] = rxSh_ff;
          nxt_rxCnt = rxCnt_ff + 5'h01;
          if ({3'h0, nxt_rxCnt} == rxLen_ff) nxt_rxSt = hsp_pkg::RX_CRC_LO;  // see R9
        end
        hsp_pkg::RX_CRC_LO: begin
          nxt_rxCrcLo = rxSh_ff;
          nxt_rxSt    = hsp_pkg::RX_CRC_HI;
        end
        hsp_pkg::RX_CRC_HI: nxt_rxSt = hsp_pkg::RX_TYPE;
      endcase
    end
    // new packet answer overrides the load clear
    if (pktOk) begin
      nxt_respPend = 1'b1;
      nxt_respCode = rxType_ff[5:0];  // see R23
      nxt_respOk   = 1'b0;
      nxt_respLen  = 8'h00;
      if (rxType_ff[7:6] == `HSP_CLS_CMD) begin
        if (rxType_ff[5:0] == `HSP_CODE_PING && rxLen_ff <= `HSP_PING_MAX) begin
          nxt_respOk  = 1'b1;
          nxt_respLen = rxLen_ff;
        end
        if (rxType_ff[5:0] == `HSP_CODE_BAUD && rxLen_ff == `HSP_BAUD_LEN &&
            rxBuf_ff[0] <= `HSP_BAUD_MAXSEL) begin
          nxt_respOk   = 1'b1;
          nxt_baudPend = 1'b1;  // see R2
          nxt_baudVal  = rxBuf_ff[0][0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxSt_ff     <= hsp_pkg::RX_TYPE;
      rxCnt_ff    <= 5'h00;
      rxType_ff   <= 8'h00;
      rxLen_ff    <= 8'h00;
      rxCrcLo_ff  <= 8'h00;
      rxBuf_ff    <= '{default: 8'h00};
      respPend_ff <= 1'b0;
      respOk_ff   <= 1'b0;
      respCode_ff <= 6'h00;
      respLen_ff  <= 8'h00;
      baudPend_ff <= 1'b0;
      baudVal_ff  <= 1'b0;
      baudFast_ff <= 1'b0;  // see R1
      crcErr_ff   <= 1'b0;
    end else if (clkEn) begin
      rxSt_ff     <= nxt_rxSt;
      rxCnt_ff    <= nxt_rxCnt;
      rxType_ff   <= nxt_rxType;
      rxLen_ff    <= nxt_rxLen;
      rxCrcLo_ff  <= nxt_rxCrcLo;
      rxBuf_ff    <= nxt_rxBuf;
      respPend_ff <= nxt_respPend;
      respOk_ff   <= nxt_respOk;
      respCode_ff <= nxt_respCode;
      respLen_ff  <= nxt_respLen;
      baudPend_ff <= nxt_baudPend;
      baudVal_ff  <= nxt_baudVal;
      baudFast_ff <= nxt_baudFast;
      crcErr_ff   <= crcBad;
    end
  end

  // ****************************************************************
  // report sources
  // ****************************************************************
  logic [5:0]            keyPrev_ff;
  logic [11:0]           keyPend_ff, nxt_keyPend;
  logic [3:0]            fanPend_ff, nxt_fanPend;
  logic [31:0]           tempPend_ff, nxt_tempPend;
  logic [4:0]            tempSel_ff, keyIdx, fanIdx;
  logic [`HSP_TMR_W-1:0] fanTmr_ff, nxt_fanTmr, tempTmr_ff, nxt_tempTmr;
  logic                  ldKey, ldFan, ldTemp;

  assign keyIdx = lowIdx({20'h0_0000, keyPend_ff});
  assign fanIdx = lowIdx({28'h000_0000, fanPend_ff});

  always_comb begin
    nxt_keyPend  = keyPend_ff;
    nxt_fanPend  = fanPend_ff;
    nxt_tempPend = tempPend_ff;
    nxt_fanTmr   = fanTmr_ff + `HSP_TMR_W'(1);
    nxt_tempTmr  = tempTmr_ff + `HSP_TMR_W'(1);
    if (ldKey) nxt_keyPend[keyIdx[3:0]] = 1'b0;
    if (ldFan) nxt_fanPend[fanIdx[1:0]] = 1'b0;
    if (ldTemp) nxt_tempPend[tempSel_ff] = 1'b0;
    // events set after the clear so a same-cycle clear never drops them
    nxt_keyPend = nxt_keyPend | {~keyLvl & keyPrev_ff & keyRelEn,
                                 keyLvl & ~keyPrev_ff & keyPressEn};  // see R16 see R17
    if (fanTmr_ff == `HSP_TMR_W'(FAN_PERIOD_CYC - 1)) begin
      nxt_fanTmr  = '0;
      nxt_fanPend = nxt_fanPend | fanRptEn;  // see R18
    end
    if (tempTmr_ff == `HSP_TMR_W'(TEMP_PERIOD_CYC - 1)) begin
      nxt_tempTmr  = '0;
      nxt_tempPend = nxt_tempPend | tempRptEn;  // see R21 see R22
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      keyPrev_ff  <= 6'h00;
      keyPend_ff  <= 12'h000;
      fanPend_ff  <= 4'h0;
      tempPend_ff <= 32'h0000_0000;
      tempSel_ff  <= 5'h00;
      fanTmr_ff   <= '0;
      tempTmr_ff  <= '0;
    end else if (clkEn) begin
      keyPrev_ff  <= keyLvl;
      keyPend_ff  <= nxt_keyPend;
      fanPend_ff  <= nxt_fanPend;
      tempPend_ff <= nxt_tempPend;
      tempSel_ff  <= lowIdx(nxt_tempPend);
      fanTmr_ff   <= nxt_fanTmr;
      tempTmr_ff  <= nxt_tempTmr;
    end
  end

  // ****************************************************************
  // packet transmitter
  // ****************************************************************
  hsp_pkg::hsp_tx_e   txSt_ff, nxt_txSt;
  logic [4:0]         txPos_ff, nxt_txPos;
  hsp_pkg::hsp_byte_t txType_ff, nxt_txType, txLen_ff, nxt_txLen, txByte;
  hsp_pkg::hsp_byte_t txBuf_ff [`HSP_BUF_DEPTH];
  hsp_pkg::hsp_byte_t nxt_txBuf [`HSP_BUF_DEPTH];
  logic               txIsResp_ff, nxt_txIsResp, canLd, utGo, txFinish, inPay;
  logic               utOn_ff, nxt_utOn, txPin_ff, nxt_txPin;
  logic [11:0]        utTmr_ff, nxt_utTmr;
  logic [3:0]         utBit_ff, nxt_utBit;
  logic [9:0]         utSh_ff, nxt_utSh;
  logic [15:0]        txCrc, txCrcOut;
  logic [7:0]         posX;

  assign txCrcOut = txCrc ^ `HSP_CRC_XOROUT;
  assign posX     = {3'h0, txPos_ff};
  assign inPay    = posX < txLen_ff + 8'h02;
  assign utGo     = txSt_ff == hsp_pkg::TX_SEND && !utOn_ff;
  assign txFinish = utGo && posX == txLen_ff + 8'h03;
  assign baudGo   = baudPend_ff && !respPend_ff && txSt_ff == hsp_pkg::TX_IDLE && !utOn_ff;
  assign canLd    = txSt_ff == hsp_pkg::TX_IDLE && !baudGo;
  assign ldResp   = canLd && respPend_ff;
  assign ldKey    = canLd && !respPend_ff && keyPend_ff != 12'h000;
  assign ldFan    = canLd && !respPend_ff && keyPend_ff == 12'h000 && fanPend_ff != 4'h0;
  assign ldTemp   = canLd && !respPend_ff && keyPend_ff == 12'h000 && fanPend_ff == 4'h0 &&
                    tempPend_ff[tempSel_ff];

  hsp_crc16 uTxCrc (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .clr     (txPos_ff == 5'h00),
    .upd     (utGo && inPay),  // see R8
    .dat     (txByte),
    .crc     (txCrc)
  );

  always_comb begin
    if (txPos_ff == 5'h00) txByte = txType_ff;  // see R3
    else if (txPos_ff == `HSP_POS_LEN) txByte = txLen_ff;
    else if (inPay) txByte = txBuf_ff[5'(txPos_ff - `HSP_POS_DATA)];
    else if (posX == txLen_ff + 8'h02) txByte = txCrcOut[7:0];  // see R8 see R9
    else txByte = txCrcOut[15:8];
  end

  always_comb begin
    nxt_txSt     = txSt_ff;
    nxt_txPos    = txPos_ff;
    nxt_txType   = txType_ff;
    nxt_txLen    = txLen_ff;
    nxt_txBuf    = txBuf_ff;
    nxt_txIsResp = txIsResp_ff;
    if (canLd && (ldResp || ldKey || ldFan || ldTemp)) begin
      nxt_txSt     = hsp_pkg::TX_SEND;
      nxt_txPos    = 5'h00;
      nxt_txIsResp = ldResp;
    end
    if (ldResp) begin  // see R6 see R23 see R11
      nxt_txType = {respOk_ff ? `HSP_CLS_RSP : `HSP_CLS_ERR, respCode_ff};  // see R4 see R5
      nxt_txLen  = respLen_ff;
      nxt_txBuf  = rxBuf_ff;
    end else if (ldKey) begin
      nxt_txType   = {`HSP_CLS_RPT, `HSP_RPT_KEY};  // see R16
      nxt_txLen    = `HSP_LEN_KEY;
      nxt_txBuf[0] = {3'h0, keyIdx} + 8'h01;  // see R17 see R25
    end else if (ldFan) begin
      nxt_txType   = {`HSP_CLS_RPT, `HSP_RPT_FAN};  // see R18
      nxt_txLen    = `HSP_LEN_FAN;
      nxt_txBuf[0] = {3'h0, fanIdx};  // see R19
      nxt_txBuf[1] = fanTach[fanIdx[1:0]*8 +: 8];
      nxt_txBuf[2] = fanTicks[fanIdx[1:0]*16+8 +: 8];
      nxt_txBuf[3] = fanTicks[fanIdx[1:0]*16 +: 8];
    end else if (ldTemp) begin
      nxt_txType   = {`HSP_CLS_RPT, `HSP_RPT_TEMP};  // see R24
      nxt_txLen    = `HSP_LEN_TEMP;
      nxt_txBuf[0] = {3'h0, tempSel_ff};
      nxt_txBuf[1] = tempData[15:8];
      nxt_txBuf[2] = tempData[7:0];
    end
    if (utGo) nxt_txPos = txPos_ff + 5'h01;
    if (txFinish) nxt_txSt = hsp_pkg::TX_IDLE;
    // serialiser: start bit, eight data bits, stop bit
    nxt_utOn  = utOn_ff;
    nxt_utTmr = utTmr_ff;
    nxt_utBit = utBit_ff;
    nxt_utSh  = utSh_ff;
    nxt_txPin = utOn_ff ? utSh_ff[0] : 1'b1;
    if (utGo) begin
      nxt_utOn  = 1'b1;
      nxt_utSh  = {1'b1, txByte, 1'b0};  // see R1
      nxt_utTmr = bitDiv - 12'h001;
      nxt_utBit = `HSP_BIT_START;
    end else if (utOn_ff) begin
      if (utTmr_ff != 12'h000) nxt_utTmr = utTmr_ff - 12'h001;
      else begin
        nxt_utTmr = bitDiv - 12'h001;
        nxt_utSh  = {1'b1, utSh_ff[9:1]};
        nxt_utBit = utBit_ff + 4'h1;
        if (utBit_ff == `HSP_BIT_STOP) nxt_utOn = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      txSt_ff     <= hsp_pkg::TX_IDLE;
      txPos_ff    <= 5'h00;
      txType_ff   <= 8'h00;
      txLen_ff    <= 8'h00;
      txBuf_ff    <= '{default: 8'h00};
      txIsResp_ff <= 1'b0;
      utOn_ff     <= 1'b0;
      utTmr_ff    <= 12'h000;
      utBit_ff    <= 4'h0;
      utSh_ff     <= 10'h3FF;
      txPin_ff    <= 1'b1;
    end else if (clkEn) begin
      txSt_ff     <= nxt_txSt;
      txPos_ff    <= nxt_txPos;
      txType_ff   <= nxt_txType;
      txLen_ff    <= nxt_txLen;
      txBuf_ff    <= nxt_txBuf;
      txIsResp_ff <= nxt_txIsResp;
      utOn_ff     <= nxt_utOn;
      utTmr_ff    <= nxt_utTmr;
      utBit_ff    <= nxt_utBit;
      utSh_ff     <= nxt_utSh;
      txPin_ff    <= nxt_txPin;
    end
  end

  assign txPin    = txPin_ff;
  assign tempSel  = tempSel_ff;
  assign baudFast = baudFast_ff;
  assign crcErr   = crcErr_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [`HSP_TMR_W-1:0] ackCnt_ff, nxt_ackCnt;
  logic                  ackWait_ff, nxt_ackWait;

  always_comb begin
    nxt_ackWait = (ackWait_ff && !(txFinish && txIsResp_ff)) || pktOk;
    nxt_ackCnt  = ackWait_ff ? ackCnt_ff + `HSP_TMR_W'(1) : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ackWait_ff <= 1'b0;
      ackCnt_ff  <= '0;
    end else if (clkEn) begin
      ackWait_ff <= nxt_ackWait;
      ackCnt_ff  <= nxt_ackCnt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_reset_slow;
    $fell(sys_rst) |-> !baudFast_ff && txPin_ff && !crcErr_ff;
  endproperty
  a_reset_slow: assert property (p_reset_slow) else $error("link not slow after reset"); // see R1
  property p_baud_cause;
    $rose(baudFast_ff) |-> $past(baudPend_ff) && $past(baudVal_ff) && !utOn_ff;
  endproperty
  a_baud_cause: assert property (p_baud_cause) else $error("baud switched without cmd"); // see R2
  property p_frame_end;
    txFinish |-> posX == txLen_ff + 8'h03 && !inPay;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame length wrong"); // see R9
  property p_len_drop;
    rxVld_ff && rxSt_ff == hsp_pkg::RX_LEN && rxSh_ff > `HSP_MAX_LEN |=> rxSt_ff == hsp_pkg::RX_TYPE;
  endproperty
  a_len_drop: assert property (p_len_drop) else $error("oversize length accepted"); // see R7
  property p_crc_drop;
    crcBad && !respPend_ff && !ackWait_ff |=> !respPend_ff ##1 !ackWait_ff;
  endproperty
  a_crc_drop: assert property (p_crc_drop) else $error("bad crc packet answered"); // see R26
  property p_code_echo;
    ldResp |=> txType_ff[5:0] == $past(respCode_ff) && txType_ff[6] && txIsResp_ff;
  endproperty
  a_code_echo: assert property (p_code_echo) else $error("ack code mismatch"); // see R23
  property p_key_rpt;
    ldKey |=> txType_ff == {`HSP_CLS_RPT, `HSP_RPT_KEY} && txLen_ff == `HSP_LEN_KEY &&
              txBuf_ff[0] != 8'h00 && txBuf_ff[0] <= `HSP_KEY_CODE_MAX;
  endproperty
  a_key_rpt: assert property (p_key_rpt) else $error("key report malformed"); // see R17
  property p_fan_rpt;
    ldFan |=> txType_ff == {`HSP_CLS_RPT, `HSP_RPT_FAN} && txLen_ff == `HSP_LEN_FAN &&
              txBuf_ff[0] <= `HSP_FAN_MAX_IDX;
  endproperty
  a_fan_rpt: assert property (p_fan_rpt) else $error("fan report malformed"); // see R19
  property p_ack_time;
    ackCnt_ff < `HSP_TMR_W'(ACK_CYC);
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("ack too late"); // see R10
endmodule : hsp_framer

/* File: testbench/hsp_host_model.sv */
`timescale 1ns/100ps
module hsp_host_model (
  input  wire logic ref_clk,
  output logic      hostTx,
  input  wire logic devTx
);
  int         bitCyc = 2604;
  logic [7:0] rxQ[$];
  initial hostTx = 1'b1;
  // start, 8 data lsb first, stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk);
      hostTx = f[i];
      repeat (bitCyc - 1) @(negedge ref_clk);
    end
  endtask : send_byte
  // buffer bytes with a high stop bit, read back in arrival order
  always begin
    logic [7:0] b;
    @(negedge devTx);
    repeat (bitCyc / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitCyc) @(posedge ref_clk);
      b[i] = devTx;
    end
    repeat (bitCyc) @(posedge ref_clk);
    if (devTx === 1'b1) rxQ.push_back(b);
  end
endmodule : hsp_host_model

/* File: testbench/hsp_framer_tb.sv */
`timescale 1ns/100ps
module hsp_framer_tb;
  typedef struct {logic [7:0] t, l, d, et, el;} hsp_row_s;
  logic        ref_clk  = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        rxPin, txPin, baudFast, crcErr;
  logic        clkEn    = 1'b1;
  logic [31:0] tempRptEn = 32'h0000_0000;
  logic [15:0] tempData = 16'hBEEF;
  logic [5:0]  keyLvl   = 6'h00;
  logic [5:0]  keyEn    = 6'h3F;
  logic [3:0]  fanRptEn = 4'h0;
  logic [31:0] fanTach  = 32'h0000_0000;
  logic [63:0] fanTicks = 64'h0000_0000_0000_0000;
  logic [4:0]  tempSel;
  int          num_errors = 0, total_checks = 0, nCrc = 0;
  hsp_row_s    rows[6] = '{'{8'h00, 8'h01, 8'h55, 8'h40, 8'h01},
    '{8'h00, 8'h10, 8'hA5, 8'h40, 8'h10}, '{8'h00, 8'h11, 8'h3C, 8'hC0, 8'h00},
    '{8'h05, 8'h00, 8'h00, 8'hC5, 8'h00}, '{8'h4A, 8'h00, 8'h00, 8'hCA, 8'h00},
    '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00}};
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (crcErr === 1'b1) nCrc++;
  hsp_host_model host (.ref_clk(ref_clk), .hostTx(rxPin), .devTx(txPin));
  hsp_framer #(.FAN_PERIOD_CYC(2000), .TEMP_PERIOD_CYC(4000)) DUT (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .clkEn(clkEn), .rxPin(rxPin), .txPin(txPin), .keyLvl(keyLvl),
    .keyPressEn(keyEn), .keyRelEn(keyEn), .fanRptEn(fanRptEn), .fanTach(fanTach),
    .fanTicks(fanTicks), .tempRptEn(tempRptEn), .tempData(tempData),
    .tempSel(tempSel), .baudFast(baudFast), .crcErr(crcErr));
  task automatic chk8(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (e !== s) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk8
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return ~c;
  endfunction : crc
  task automatic send_pkt(input logic [7:0] t, l, d, input logic bad);
    logic [7:0]  b[$];
    logic [15:0] c;
    b = {t, l};
    for (int i = 0; i < l; i++) b.push_back(d);
    c = crc(b) ^ {15'h0000, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) host.send_byte(b[i]);
  endtask : send_pkt
  task automatic get_pkt(input logic [7:0] t, l, input logic [7:0] d[4]);
    logic [7:0] p[$];
    int         n;
    n = 0;
    while (host.rxQ.size() < 2 || host.rxQ.size() < host.rxQ[1] + 4) begin
      @(posedge ref_clk);
      n++;
      if (n > 400000) begin
        chk8("pktWait", 1, 0);
        return;
      end
    end
    for (int i = 0; i < l + 2; i++) p.push_back(host.rxQ.pop_front());
    chk8("type", t, p[0]);
    chk8("len", l, p[1]);
    for (int i = 0; i < l; i++) chk8("data", d[i % 4], p[2 + i]);
    chk8("crc", crc(p), {host.rxQ[1], host.rxQ[0]});
    void'(host.rxQ.pop_front());
    void'(host.rxQ.pop_front());
  endtask : get_pkt
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    repeat (2000000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    chk8("rstOut", 4'h9, {txPin, baudFast, crcErr, tempSel == 5'h00});
    sys_rst = 1'b0;
    send_pkt(8'h21, 8'h01, 8'h01, 1'b0);
    get_pkt(8'h61, 8'h00, '{4{8'h00}});
    repeat (3000) @(posedge ref_clk);
    chk8("baudFast", 1, baudFast);
    host.bitCyc = 434;
    $display("baud test done");
    foreach (rows[i]) begin
      send_pkt(rows[i].t, rows[i].l, rows[i].d, 1'b0);
      get_pkt(rows[i].et, rows[i].el, '{4{rows[i].d}});
    end
    $display("row tests done");
    host.send_byte(8'h00);
    host.send_byte(8'h13);
    send_pkt(8'h00, 8'h01, 8'h77, 1'b1);
    repeat (20000) @(posedge ref_clk);
    chk8("crcErrCnt", 1, nCrc);
    chk8("noAnswer", 0, host.rxQ.size());
    $display("bad checksum test done");
    @(negedge ref_clk) keyLvl = 6'h20;
    get_pkt(8'h80, 8'h01, '{4{8'h06}});
    @(negedge ref_clk) keyLvl = 6'h00;
    get_pkt(8'h80, 8'h01, '{4{8'h0C}});
    $display("key test done");
    @(negedge ref_clk) clkEn = 1'b0;
    keyLvl = 6'h02;
    repeat (20) @(negedge ref_clk);
    keyLvl = 6'h00;
    clkEn = 1'b1;
    @(negedge ref_clk) keyEn = 6'h00;
    keyLvl = 6'h01;
    repeat (5) @(negedge ref_clk);
    keyLvl = 6'h00;
    repeat (5) @(negedge ref_clk);
    keyEn = 6'h3F;
    repeat (9000) @(posedge ref_clk);
    chk8("noKeyRpt", 0, host.rxQ.size());
    $display("freeze test done");
    @(negedge ref_clk) tempRptEn = 32'h0000_0008;
    repeat (4000) @(negedge ref_clk);
    tempRptEn = 32'h0000_0000;
    get_pkt(8'h82, 8'h03, '{8'h03, 8'hBE, 8'hEF, 8'h00});
    $display("temp test done");
    @(negedge ref_clk);
    fanTach = 32'h0007_0000;
    fanTicks = 64'h0000_1234_0000_0000;
    fanRptEn = 4'h4;
    get_pkt(8'h81, 8'h04, '{8'h02, 8'h07, 8'h12, 8'h34});
    $display("fan test done");
    @(negedge ref_clk) sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk8("rstAgain", 4'h9, {txPin, baudFast, crcErr, tempSel == 5'h00});
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    $display("reset test done");
    final_report();
  end
endmodule : hsp_framer_tb
